// File: rfscr_host.sv
/*
  rfscr_host: host model that reads status registers and FIFO data.
  Assumes one-cycle registered answers from the device on clk and a
  caller that enters each task just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module rfscr_host (
  input  wire logic       clk,
  output logic            reg_rd,
  output logic [5:0]      reg_addr,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic            fifo_rd,
  input  wire logic [7:0] fifo_rdata,
  input  wire logic       fifo_rvalid
);
  initial begin
    reg_rd   = 1'h0;
    reg_addr = 6'h00;
    fifo_rd  = 1'h0;
  end

  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    reg_rd   = 1'h1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd   = 1'h0;
    // released address does not keep its value
    reg_addr = ~a;
    d        = reg_rvalid ? reg_rdata : 8'hxx;
    @(posedge clk);
    #1;
  endtask : rd_reg

  task automatic rd_fifo(output logic [7:0] d);
    fifo_rd = 1'h1;
    @(posedge clk);
    #1;
    fifo_rd = 1'h0;
    d       = fifo_rvalid ? fifo_rdata : 8'hxx;
    @(posedge clk);
    #1;
  endtask : rd_fifo

  // count first, then flags, flags copy kept by caller
  task automatic read_status(output logic [7:0] cnt, output logic [7:0] flg);
    rd_reg(rfscr_pkg::ADDR_UNREAD_COUNT, cnt);
    rd_reg(rfscr_pkg::ADDR_COND_FLAGS, flg);
  endtask : read_status

endmodule : rfscr_host

`default_nettype wire

// File: rfscr_pkg.sv
/*
  rfscr_pkg: register map, field layouts, reset values and carrier types
  for the receive FIFO status and collision reporting block.
  Assumes a single 40 MHz clock domain and a host that reads the status
  registers through a plain read strobe port.
*/
// What this block does
// - report unread FIFO byte count as 7-bit binary, range 0 to 96
// - set underflow when host reads more bytes than the FIFO holds
// - flag an incomplete last byte and give its valid bit count
// - store incomplete last byte bits in the low positions of the byte
// - flag missing parity of last byte and signal it as framing error
// - while FIFO empty, count reads 0 and incomplete flag/count read clear
// - reading second status register clears incomplete, bit count, parity
// - status and collision registers clear at reset and set-default
// - on collision record whole bytes (4 bits) and bits before (3 bits)
// - record collision only within anticollision frame length
// - mark parity-bit collision, report as error only on first collision
`default_nettype none

package rfscr_pkg;

  // storage size and byte counter
  localparam int         FIFO_BYTES      = 96;
  localparam logic [6:0] FIFO_FULL_COUNT = 7'h60;
  localparam logic [6:0] FIFO_LAST_INDEX = 7'h5f;

  // staging buffer in front of the storage
  localparam int STAGE_WIDTH = 8;
  localparam int STAGE_DEPTH = 8;

  // register addresses
  localparam logic [5:0] ADDR_UNREAD_COUNT = 6'h1a;
  localparam logic [5:0] ADDR_COND_FLAGS   = 6'h1b;
  localparam logic [5:0] ADDR_COLL_POS     = 6'h1c;

  // reset values and the answer to unmapped reads
  localparam logic [6:0] RST_COUNT = 7'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_COLL  = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // longest byte offset still inside an anticollision frame
  localparam logic [7:0] COL_MAX_BYTES = 8'h0f;

  // condition flags register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       unused;
    logic       underflow;
    logic       overflow;
    logic       incomplete;
    logic [2:0] partial_byte_bit_count;
    logic       last_parity_absent_flag;
  } rfscr_flags_t;

  // collision position register layout
  typedef struct packed {
    logic [3:0] byte_count;
    logic [2:0] bit_count;
    logic       parity_collision_flag;
  } rfscr_coll_t;

  // frame end information that comes with the last received byte
  typedef struct packed {
    logic [2:0] valid_bits;
    logic       parity_absent;
  } rfscr_end_t;

  // collision report from the receiver
  typedef struct packed {
    logic [7:0] byte_pos;
    logic [2:0] bit_pos;
    logic       in_parity;
  } rfscr_col_t;

endpackage : rfscr_pkg

`default_nettype wire

// File: rfscr_top.sv
/*
  rfscr_fifo: parameterised staging FIFO with valid/ready on both sides.
  rfscr_top: 96-byte receive storage, unread byte count, condition flags
  and collision position register, read by the host through strobes.
  Assumes all inputs synchronous to MCLK and one-cycle event pulses.
*/
`timescale 1ns/1ps
`default_nettype none

module rfscr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != FULL);
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // depth is a power of two, pointers wrap naturally
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_stage_bound: assert property (count <= FULL)
    else $error("staging fifo count above depth");

endmodule : rfscr_fifo

module rfscr_top (
  input  wire logic                   MCLK,
  input  wire logic                   RSTN,
  input  wire logic                   SET_DEFAULT,
  input  wire logic                   RX_VALID,
  output logic                        RX_READY,
  input  wire logic [7:0]             RX_DATA,
  input  wire logic                   RX_LAST,
  input  wire rfscr_pkg::rfscr_end_t  RX_END_INFO,
  input  wire logic                   RX_START,
  input  wire logic                   COL_EVENT,
  input  wire rfscr_pkg::rfscr_col_t  COL_INFO,
  input  wire logic                   REG_RD,
  input  wire logic [5:0]             REG_ADDR,
  output logic [7:0]                  REG_RDATA,
  output logic                        REG_RVALID,
  input  wire logic                   FIFO_RD,
  output logic [7:0]                  FIFO_RDATA,
  output logic                        FIFO_RVALID,
  output logic                        FRAMING_ERR,
  output logic                        COL_PARITY_ERR
);

  logic [7:0]              mem [0:rfscr_pkg::FIFO_BYTES-1];
  logic [6:0]              wr_ptr;
  logic [6:0]              rd_ptr;
  logic [6:0]              count;
  rfscr_pkg::rfscr_flags_t flags;
  rfscr_pkg::rfscr_flags_t flags_view;
  rfscr_pkg::rfscr_coll_t  coll;
  logic                    col_seen;
  logic [7:0]              stage_in;
  logic                    st_valid;
  logic [7:0]              st_data;
  logic                    drain;
  logic                    pop;
  logic                    rx_end;
  logic                    underflow;
  logic                    overflow;
  logic                    rd_flags;
  logic                    col_take;
  logic                    empty;
  logic [7:0]              rd_value;

  function automatic logic [7:0] lsb_mask(input logic [2:0] bits);
    lsb_mask = (bits == 3'h0) ? 8'hff : ~(8'hff << bits);
  endfunction : lsb_mask

  function automatic logic [6:0] bump_ptr(input logic [6:0] ptr);
    bump_ptr = (ptr == rfscr_pkg::FIFO_LAST_INDEX) ? 7'h00 : ptr + 7'h01;
  endfunction : bump_ptr

  assign rx_end = RX_VALID && RX_READY && RX_LAST;

  // upper bits of a partial last byte are forced to zero
  assign stage_in = RX_LAST ? (RX_DATA & lsb_mask(RX_END_INFO.valid_bits))
                            : RX_DATA;

  rfscr_fifo #(
    .WIDTH (rfscr_pkg::STAGE_WIDTH),
    .DEPTH (rfscr_pkg::STAGE_DEPTH)
  ) u_stage (
    .clk       (MCLK),
    .rst_n     (RSTN),
    .in_valid  (RX_VALID),
    .in_ready  (RX_READY),
    .in_data   (stage_in),
    .out_valid (st_valid),
    .out_ready (drain),
    .out_data  (st_data)
  );

  // storage full stalls the staging buffer, which then stalls the receiver
  assign drain     = st_valid && (count != rfscr_pkg::FIFO_FULL_COUNT);
  assign pop       = FIFO_RD && (count != 7'h00);
  assign underflow = FIFO_RD && (count == 7'h00);
  assign overflow  = RX_VALID &&
                     (count == rfscr_pkg::FIFO_FULL_COUNT);
  assign rd_flags  = REG_RD && (REG_ADDR == rfscr_pkg::ADDR_COND_FLAGS);
  assign empty     = (count == 7'h00) && !st_valid;

  always_ff @(posedge MCLK) begin
    if (drain) begin
      mem[wr_ptr] <= st_data;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_ptr <= 7'h00;
    end else if (SET_DEFAULT) begin
      wr_ptr <= 7'h00;
    end else if (drain) begin
      wr_ptr <= bump_ptr(wr_ptr);
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_ptr <= 7'h00;
    end else if (SET_DEFAULT) begin
      rd_ptr <= 7'h00;
    end else if (pop) begin
      rd_ptr <= bump_ptr(rd_ptr);
    end
  end

  // unread byte count, never above the storage size
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      count <= rfscr_pkg::RST_COUNT;
    end else if (SET_DEFAULT) begin
      count <= rfscr_pkg::RST_COUNT;
    end else if (drain && !pop) begin
      count <= count + 7'h01;
    end else if (pop && !drain) begin
      count <= count - 7'h01;
    end
  end

  // a read past the end answers zero and only raises underflow
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      FIFO_RDATA  <= 8'h00;
      FIFO_RVALID <= 1'b0;
    end else begin
      FIFO_RDATA  <= pop ? mem[rd_ptr] : 8'h00;
      FIFO_RVALID <= FIFO_RD;
    end
  end

  // read clear first, hardware sets afterwards so a set wins
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      flags <= rfscr_pkg::rfscr_flags_t'(rfscr_pkg::RST_FLAGS);
    end else if (SET_DEFAULT) begin
      flags <= rfscr_pkg::rfscr_flags_t'(rfscr_pkg::RST_FLAGS);
    end else begin
      if (rd_flags) begin
        flags.underflow               <= 1'b0;
        flags.overflow                <= 1'b0;
        flags.incomplete              <= 1'b0;
        flags.partial_byte_bit_count  <= 3'h0;
        flags.last_parity_absent_flag <= 1'b0;
      end
      if (underflow) begin
        flags.underflow <= 1'b1;
      end
      if (overflow) begin
        flags.overflow <= 1'b1;
      end
      if (rx_end) begin
        flags.incomplete <= (RX_END_INFO.valid_bits != 3'h0);
        flags.partial_byte_bit_count  <= RX_END_INFO.valid_bits;
        flags.last_parity_absent_flag <= RX_END_INFO.parity_absent;
      end
    end
  end

  // empty storage and staging buffer hide the partial byte description
  always_comb begin
    flags_view        = flags;
    flags_view.unused = 1'b0;
    if (empty) begin
      flags_view.incomplete             = 1'b0;
      flags_view.partial_byte_bit_count = 3'h0;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      FRAMING_ERR <= 1'b0;
    end else begin
      FRAMING_ERR <= rx_end && RX_END_INFO.parity_absent;
    end
  end

  // only the first collision of a frame is recorded
  assign col_take = COL_EVENT && !col_seen &&
                    (COL_INFO.byte_pos <= rfscr_pkg::COL_MAX_BYTES);

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      col_seen <= 1'b0;
    end else if (SET_DEFAULT) begin
      col_seen <= 1'b0;
    end else if (COL_EVENT) begin
      col_seen <= 1'b1;
    end else if (RX_START) begin
      col_seen <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      coll <= rfscr_pkg::rfscr_coll_t'(rfscr_pkg::RST_COLL);
    end else if (SET_DEFAULT) begin
      coll <= rfscr_pkg::rfscr_coll_t'(rfscr_pkg::RST_COLL);
    end else if (col_take) begin
      coll.byte_count            <= COL_INFO.byte_pos[3:0];
      coll.bit_count             <= COL_INFO.bit_pos;
      coll.parity_collision_flag <= COL_INFO.in_parity;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      COL_PARITY_ERR <= 1'b0;
    end else begin
      COL_PARITY_ERR <= COL_EVENT && !col_seen &&
                        COL_INFO.in_parity;
    end
  end

  always_comb begin
    unique case (REG_ADDR)
      rfscr_pkg::ADDR_UNREAD_COUNT: rd_value = {1'b0, count};
      rfscr_pkg::ADDR_COND_FLAGS:   rd_value = flags_view;
      rfscr_pkg::ADDR_COLL_POS:     rd_value = coll;
      default:                      rd_value = rfscr_pkg::RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RDATA  <= REG_RD ? rd_value : 8'h00;
      REG_RVALID <= REG_RD;
    end
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  a_count_range: assert property (
    count <= rfscr_pkg::FIFO_FULL_COUNT)
    else $error("unread count above storage size");
  // a staged byte may still land while the empty read is refused
  a_underflow_set: assert property (
    FIFO_RD && count == 7'h00 && !SET_DEFAULT
    |=> flags.underflow && FIFO_RDATA == 8'h00 && count == 7'($past(drain)))
    else $error("empty read did not raise underflow");
  a_overflow_set: assert property (
    overflow && !SET_DEFAULT |=> flags.overflow ##1 flags.overflow || rd_flags
      || SET_DEFAULT || $past(rd_flags) || $past(SET_DEFAULT))
    else $error("arrival while full did not raise overflow");
  a_partial_flag: assert property (
    rx_end && RX_END_INFO.valid_bits != 3'h0 && !SET_DEFAULT
    |=> flags.incomplete && flags.partial_byte_bit_count ==
        $past(RX_END_INFO.valid_bits))
    else $error("partial last byte not described");
  a_partial_lsb: assert property (
    rx_end && RX_END_INFO.valid_bits == 3'h3 |-> stage_in[7:3] == 5'h00)
    else $error("partial byte upper bits not cleared");
  a_parity_frame: assert property (
    rx_end && RX_END_INFO.parity_absent && !SET_DEFAULT
    |=> FRAMING_ERR && flags.last_parity_absent_flag)
    else $error("missing parity not flagged");
  a_empty_view: assert property (
    REG_RD && REG_ADDR == rfscr_pkg::ADDR_COND_FLAGS && empty
    |=> REG_RDATA[4:1] == 4'h0)
    else $error("empty fifo shows partial byte");
  a_read_clear: assert property (
    rd_flags && !rx_end && !SET_DEFAULT
    |=> !flags.incomplete && !flags.last_parity_absent_flag &&
        flags.partial_byte_bit_count == 3'h0)
    else $error("status read did not clear partial byte flags");
  a_default_clear: assert property (
    SET_DEFAULT |=> count == 7'h00 && coll == rfscr_pkg::RST_COLL &&
                    flags == rfscr_pkg::RST_FLAGS)
    else $error("set default did not clear registers");
  a_coll_record: assert property (
    col_take && !SET_DEFAULT
    |=> coll.byte_count == $past(COL_INFO.byte_pos[3:0]) &&
        coll.bit_count == $past(COL_INFO.bit_pos))
    else $error("collision position not recorded");
  a_coll_hold: assert property (
    COL_EVENT && COL_INFO.byte_pos > rfscr_pkg::COL_MAX_BYTES && !SET_DEFAULT
    |=> $stable(coll))
    else $error("long frame collision changed position");
  a_parity_first: assert property (
    COL_EVENT && col_seen |=> !COL_PARITY_ERR)
    else $error("later parity collision reported as error");

endmodule : rfscr_top

`default_nettype wire

// File: tb_rx_fifo_status_collision_report.sv
/*
  tb_rx_fifo_status_collision_report: self-checking bench for rfscr_top.
  Assumes rfscr_pkg and rfscr_host compiled first; 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end

module tb_rx_fifo_status_collision_report;
  typedef struct {
    logic [7:0] n;
    logic [2:0] vb;
    logic       np;
    logic [7:0] exp_flags;
  } rfscr_row_t;

  logic                  MCLK = 1'h0;
  logic                  RSTN = 1'h0;
  logic                  SET_DEFAULT = 1'h0;
  logic                  RX_VALID = 1'h0;
  logic                  RX_LAST = 1'h0;
  logic                  RX_START = 1'h0;
  logic                  COL_EVENT = 1'h0;
  logic [7:0]            RX_DATA = 8'h00;
  rfscr_pkg::rfscr_end_t RX_END_INFO = '0;
  rfscr_pkg::rfscr_col_t COL_INFO = '0;
  logic                  RX_READY, REG_RD, REG_RVALID, FIFO_RD, FIFO_RVALID;
  logic                  FRAMING_ERR, COL_PARITY_ERR;
  logic [5:0]            REG_ADDR;
  logic [7:0]            REG_RDATA, FIFO_RDATA, cnt, flg, d, e;
  logic                  last_ferr, last_cperr;
  int                    errors = 0;
  int                    total_checks = 0;
  rfscr_row_t            rows[4] = '{
    '{8'h01, 3'h3, 1'h1, 8'h17}, '{8'h04, 3'h0, 1'h0, 8'h00},
    '{8'h02, 3'h7, 1'h0, 8'h1e}, '{8'h03, 3'h0, 1'h1, 8'h01}};

  always #12.5 MCLK = ~MCLK;

  rfscr_top dut_u (.MCLK(MCLK), .RSTN(RSTN), .SET_DEFAULT(SET_DEFAULT),
    .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_DATA(RX_DATA),
    .RX_LAST(RX_LAST), .RX_END_INFO(RX_END_INFO), .RX_START(RX_START),
    .COL_EVENT(COL_EVENT), .COL_INFO(COL_INFO), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .FIFO_RD(FIFO_RD), .FIFO_RDATA(FIFO_RDATA), .FIFO_RVALID(FIFO_RVALID),
    .FRAMING_ERR(FRAMING_ERR), .COL_PARITY_ERR(COL_PARITY_ERR));

  rfscr_host host_u (.clk(MCLK), .reg_rd(REG_RD), .reg_addr(REG_ADDR),
    .reg_rdata(REG_RDATA), .reg_rvalid(REG_RVALID), .fifo_rd(FIFO_RD),
    .fifo_rdata(FIFO_RDATA), .fifo_rvalid(FIFO_RVALID));

  task automatic final_report();
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : tick

  task automatic push(input logic [7:0] b, input logic last,
                      input logic [2:0] vb, input logic np);
    int n;
    n           = 0;
    RX_VALID    = 1'h1;
    RX_DATA     = b;
    RX_LAST     = last;
    RX_END_INFO = '{valid_bits: vb, parity_absent: np};
    while (RX_READY !== 1'h1 && n < 50) begin
      tick(1);
      n++;
    end
    tick(1);
    last_ferr = FRAMING_ERR;
    RX_VALID  = 1'h0;
    RX_LAST   = 1'h0;
    RX_DATA   = ~b;
    tick(1);
  endtask : push

  task automatic col(input logic st, input logic [7:0] bp,
                     input logic [2:0] bi, input logic par);
    RX_START = st;
    tick(1);
    RX_START  = 1'h0;
    COL_EVENT = 1'h1;
    COL_INFO  = '{byte_pos: bp, bit_pos: bi, in_parity: par};
    tick(1);
    COL_EVENT  = 1'h0;
    COL_INFO   = ~COL_INFO;
    last_cperr = COL_PARITY_ERR;
    tick(1);
  endtask : col

  initial begin
    tick(5);
    RSTN = 1'h1;
    tick(1);
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < rows[r].n; i++)
        push(8'hf0 | i[7:0], i == rows[r].n - 1, rows[r].vb, rows[r].np);
      tick(3);
      `CHK(last_ferr, rows[r].np)
      host_u.read_status(cnt, flg);
      `CHK(cnt, rows[r].n)
      `CHK(flg, rows[r].exp_flags)
      for (int i = 0; i < rows[r].n; i++) begin
        host_u.rd_fifo(d);
        e = 8'hf0 | i[7:0];
        if (i == rows[r].n - 1 && rows[r].vb != 3'h0)
          e = e & ((8'h01 << rows[r].vb) - 8'h01);
        `CHK(d, e)
      end
      host_u.rd_reg(rfscr_pkg::ADDR_COND_FLAGS, d);
      `CHK(d, 8'h00)
      host_u.rd_reg(rfscr_pkg::ADDR_UNREAD_COUNT, d);
      `CHK(d, 8'h00)
    end
    // read from empty storage
    host_u.rd_fifo(d);
    `CHK(d, 8'h00)
    host_u.read_status(cnt, flg);
    `CHK(cnt, 8'h00)
    `CHK(flg, 8'h40)
    // partial byte drained without flags read: empty view
    push(8'hff, 1'h1, 3'h5, 1'h1);
    tick(3);
    host_u.rd_fifo(d);
    `CHK(d, 8'h1f)
    host_u.rd_reg(rfscr_pkg::ADDR_COND_FLAGS, d);
    `CHK(d, 8'h01)
    // fill storage and staging until refused
    for (int i = 0; i < 104; i++) push(i[7:0], 1'h0, 3'h0, 1'h0);
    `CHK(RX_READY, 1'h0)
    host_u.read_status(cnt, flg);
    `CHK(cnt, 8'h60)
    `CHK(flg, 8'h20)
    for (int i = 0; i < 104; i++) begin
      host_u.rd_fifo(d);
      `CHK(d, i[7:0])
    end
    host_u.read_status(cnt, flg);
    `CHK(cnt, 8'h00)
    `CHK(flg, 8'h00)
    // collisions: first, later, beyond frame, parity
    col(1'h1, 8'h02, 3'h5, 1'h0);
    host_u.rd_reg(rfscr_pkg::ADDR_COLL_POS, d);
    `CHK(d, 8'h2a)
    col(1'h0, 8'h03, 3'h1, 1'h1);
    `CHK(last_cperr, 1'h0)
    col(1'h1, 8'h14, 3'h2, 1'h0);
    host_u.rd_reg(rfscr_pkg::ADDR_COLL_POS, d);
    `CHK(d, 8'h2a)
    col(1'h1, 8'h0f, 3'h7, 1'h1);
    `CHK(last_cperr, 1'h1)
    host_u.rd_reg(rfscr_pkg::ADDR_COLL_POS, d);
    `CHK(d, 8'hff)
    // set-default clears count, flags and collision position
    push(8'h0f, 1'h1, 3'h3, 1'h1);
    tick(3);
    SET_DEFAULT = 1'h1;
    tick(1);
    SET_DEFAULT = 1'h0;
    tick(1);
    host_u.read_status(cnt, flg);
    `CHK(cnt, 8'h00)
    `CHK(flg, 8'h00)
    host_u.rd_reg(rfscr_pkg::ADDR_COLL_POS, d);
    `CHK(d, 8'h00)
    // reset in mid-run
    col(1'h1, 8'h04, 3'h1, 1'h0);
    host_u.rd_reg(rfscr_pkg::ADDR_COLL_POS, d);
    `CHK(d, 8'h42)
    RSTN = 1'h0;
    tick(2);
    RSTN = 1'h1;
    tick(1);
    host_u.rd_reg(rfscr_pkg::ADDR_COLL_POS, d);
    `CHK(d, 8'h00)
    host_u.rd_reg(6'h1d, d);
    `CHK(d, rfscr_pkg::RD_UNMAPPED)
    final_report();
  end

  initial begin
    repeat (5000) @(posedge MCLK);
    errors++;
    final_report();
  end

endmodule : tb_rx_fifo_status_collision_report

`default_nettype wire
